// ===== hw/rapu_defs.svh
`ifndef RAPU_DEFS_SVH
`define RAPU_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define RAPU_SLOT_LSB        5
`define RAPU_OFF_BASE        3'h0
`define RAPU_OFF_RIGHTS      3'h1
`define RAPU_CTRL_SEL        1'h1
`define RAPU_OFF_STATUS      3'h0
`define RAPU_OFF_MASK        3'h1
`define RAPU_OFF_FAULT       3'h2

// ----------------------------------------
// field positions
// ----------------------------------------
`define RAPU_BASE_ADDR_LSB   8
`define RAPU_SLICE_MSB       7
`define RAPU_RT_UR           0
`define RAPU_RT_UW           1
`define RAPU_RT_UX           2
`define RAPU_RT_KR           3
`define RAPU_RT_KW           4
`define RAPU_RT_KX           5
`define RAPU_RT_OPEN         6
`define RAPU_RT_SKIP         7
`define RAPU_RT_SIZE_LSB     8
`define RAPU_RT_SIZE_MSB     12
`define RAPU_RT_EN           15
`define RAPU_RT_CTX_LSB      16
`define RAPU_RT_LOW_MASK     32'h0000_9fff
`define RAPU_SIZE_MIN        5'h07
`define RAPU_SUB_SHIFT       6'h02
`define RAPU_ST_VIOL         0
`define RAPU_ST_MISS         1
`define RAPU_RESP_OK         2'h0
`define RAPU_RESP_SLVERR     2'h2

`endif

// ===== hw/rapu_pkg.sv
package rapu_pkg;

  typedef enum logic [1:0] {
    RAPU_IDLE  = 2'h0,
    RAPU_WALK  = 2'h1,
    RAPU_REPLY = 2'h3
  } rapu_state_t;

  typedef enum logic [1:0] {
    RAPU_KIND_MASTER     = 2'h0,
    RAPU_KIND_SHARED     = 2'h1,
    RAPU_KIND_PERIPHERAL = 2'h2
  } rapu_kind_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [11:0] size_m1;
    logic        write;
    logic        exec;
    logic        user;
    logic        secure;
    logic [3:0]  protection_context;
  } rapu_xfer_t;

  typedef struct packed {
    logic grant;
    logic bus_error;
  } rapu_resp_t;

endpackage : rapu_pkg

// ===== hw/rapu_top.sv
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "rapu_defs.svh"

module rapu_top
  import rapu_pkg::*;
#(
  parameter int         NSTRUCT = 8,
  parameter rapu_kind_t KIND    = RAPU_KIND_SHARED
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // avalon-mm register slave
  input  wire logic [11:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic      [1:0]  avs_response_o,
  output logic             avs_waitrequest_o,
  // transfer check request
  input  wire logic        xfer_valid_i,
  input  rapu_xfer_t       xfer_i,
  output logic             xfer_ready_o,
  // transfer verdict
  output logic             resp_valid_o,
  output rapu_resp_t       resp_o,
  // interrupt
  output logic             irq_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [NSTRUCT-1:0][31:0] base;
    logic [NSTRUCT-1:0][31:0] rights;
    logic [1:0]               irq_stat;
    logic [1:0]               irq_mask;
    logic [31:0]              fault_addr;
    logic                     bus_ack;
    logic [31:0]              rdata;
    logic [1:0]               bresp;
    rapu_state_t              fsm;
    logic [26:0]              cur_blk;
    logic [26:0]              end_blk;
    rapu_xfer_t               req;
    logic                     denied;
    logic                     grant;
  } state_t;

  state_t q;
  state_t d;

  localparam bit CTX_UNIT = (KIND != RAPU_KIND_MASTER);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // region hit, size is 2^(code+1) bytes; codes below 256 bytes clamp to it
  function automatic logic region_hit(input logic [31:0] base, input logic [31:0] rt, input logic [31:0] addr);
    logic [4:0]  code;
    logic [5:0]  shift;
    logic [31:0] mask;
    logic [2:0]  sub;
    code = rt[`RAPU_RT_SIZE_MSB:`RAPU_RT_SIZE_LSB];
    if (code < `RAPU_SIZE_MIN) begin
      code = `RAPU_SIZE_MIN;
    end
    shift = {1'b0, code} + 6'h01;
    mask  = (shift[5]) ? 32'h0000_0000 : (32'hffff_ffff << shift);
    sub   = 3'((addr >> (shift - 6'h01 - `RAPU_SUB_SHIFT)) & 32'h0000_0007);
    return rt[`RAPU_RT_EN]
        && ((addr & mask) == ({base[31:`RAPU_BASE_ADDR_LSB], 8'h00} & mask))
        && !base[sub];
  endfunction : region_hit

  function automatic logic ctx_ok(input logic [31:0] rt, input logic [3:0] ctx);
    logic [15:0] bits;
    bits    = rt[31:`RAPU_RT_CTX_LSB];
    bits[0] = 1'b1;
    return bits[ctx];
  endfunction : ctx_ok

  // mode/type, secure and context checks, all must pass
  function automatic logic rights_ok(input logic [31:0] rt, input rapu_xfer_t x);
    logic mode_ok;
    logic sec_ok;
    logic pc_ok;
    if (x.write) begin
      mode_ok = x.user ? rt[`RAPU_RT_UW] : rt[`RAPU_RT_KW];
    end else if (x.exec) begin
      mode_ok = x.user ? (rt[`RAPU_RT_UR] && rt[`RAPU_RT_UX])
                       : (rt[`RAPU_RT_KR] && rt[`RAPU_RT_KX]);
    end else begin
      mode_ok = x.user ? rt[`RAPU_RT_UR] : rt[`RAPU_RT_KR];
    end
    sec_ok = rt[`RAPU_RT_OPEN] || x.secure;
    pc_ok  = !CTX_UNIT || rt[`RAPU_RT_SKIP] || ctx_ok(rt, x.protection_context);
    return mode_ok && sec_ok && pc_ok;
  endfunction : rights_ok

  // ----------------------------------------
  // structure scan for the current block
  // ----------------------------------------
  logic [31:0] blk_addr;
  logic        found;
  logic        blk_ok;
  logic [31:0] sel_rt;

  always_comb begin
    blk_addr = {q.cur_blk, 5'h00};
    found    = 1'b0;
    sel_rt   = 32'h0000_0000;
    // downward scan, first hit wins; a SKIP hit whose context fails is passed over
    for (int i = NSTRUCT - 1; i >= 0; i--) begin
      if (!found && region_hit(q.base[i], q.rights[i], blk_addr)) begin
        if (CTX_UNIT && q.rights[i][`RAPU_RT_SKIP] && !ctx_ok(q.rights[i], q.req.protection_context)) begin
          found = 1'b0;
        end else begin
          found  = 1'b1;
          sel_rt = q.rights[i];
        end
      end
    end
    blk_ok = !found || rights_ok(sel_rt, q.req);
  end

  // ----------------------------------------
  // register read decode
  // ----------------------------------------
  logic        is_ctrl;
  logic [5:0]  slot;
  logic [2:0]  word;
  logic        mapped;
  logic [31:0] rd_val;

  always_comb begin
    is_ctrl = avs_address_i[11];
    slot    = avs_address_i[10:`RAPU_SLOT_LSB];
    word    = avs_address_i[4:2];
    mapped  = 1'b0;
    rd_val  = 32'h0000_0000;
    if (is_ctrl == `RAPU_CTRL_SEL) begin
      if (slot == 6'h00) begin
        mapped = 1'b1;
        case (word)
          `RAPU_OFF_STATUS: rd_val = {30'h0, q.irq_stat};
          `RAPU_OFF_MASK:   rd_val = {30'h0, q.irq_mask};
          `RAPU_OFF_FAULT:  rd_val = q.fault_addr;
          default:          mapped = 1'b0;
        endcase
      end
    end else if (32'(slot) < NSTRUCT) begin
      mapped = 1'b1;
      case (word)
        `RAPU_OFF_BASE:   rd_val = q.base[slot];
        `RAPU_OFF_RIGHTS: begin
          rd_val = q.rights[slot] & `RAPU_RT_LOW_MASK;
          if (CTX_UNIT) begin
            rd_val[31:`RAPU_RT_CTX_LSB] = {q.rights[slot][31:`RAPU_RT_CTX_LSB+1], 1'b1};
          end
        end
        default:          mapped = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [1:0]  ev;
  logic [1:0]  clr;
  logic [31:0] last;
  logic [31:0] mask_w;

  always_comb begin
    d      = q;
    ev     = 2'h0;
    clr    = 2'h0;
    last   = xfer_i.addr + {20'h0, xfer_i.size_m1};
    // merged mask word, only the low two bits are kept
    mask_w = merge({30'h0, q.irq_mask}, avs_writedata_i, avs_byteenable_i);

    // bus: decode on first cycle, write and answer on second
    if ((avs_read_i || avs_write_i) && !q.bus_ack) begin
      d.bus_ack = 1'b1;
      d.rdata   = avs_read_i ? rd_val : 32'h0000_0000;
      d.bresp   = mapped ? `RAPU_RESP_OK : `RAPU_RESP_SLVERR;
    end else begin
      d.bus_ack = 1'b0;
      if (q.bus_ack && avs_write_i && mapped) begin
        if (is_ctrl == `RAPU_CTRL_SEL) begin
          case (word)
            `RAPU_OFF_STATUS: clr        = avs_byteenable_i[0] ? avs_writedata_i[1:0] : 2'h0;
            `RAPU_OFF_MASK:   d.irq_mask = mask_w[1:0];
            default:          d.irq_mask = q.irq_mask;
          endcase
        end else begin
          case (word)
            `RAPU_OFF_BASE:   d.base[slot]   = merge(q.base[slot], avs_writedata_i, avs_byteenable_i);
            `RAPU_OFF_RIGHTS: d.rights[slot] = merge(q.rights[slot], avs_writedata_i, avs_byteenable_i);
            default:          d.bresp        = q.bresp;
          endcase
        end
      end
    end

    // transfer walk
    case (q.fsm)
      RAPU_IDLE: begin
        if (xfer_valid_i) begin
          d.req     = xfer_i;
          d.cur_blk = xfer_i.addr[31:`RAPU_SLOT_LSB];
          d.end_blk = last[31:`RAPU_SLOT_LSB];
          d.denied  = 1'b0;
          d.fsm     = RAPU_WALK;
        end
      end
      RAPU_WALK: begin
        // one 32-byte block per cycle
        d.cur_blk = q.cur_blk + 27'h1;
        if (!found) begin
          ev[`RAPU_ST_MISS] = 1'b1;
        end
        if (!blk_ok) begin
          d.denied = 1'b1;
          if (!q.denied) begin
            d.fault_addr      = blk_addr;
            ev[`RAPU_ST_VIOL] = 1'b1;
          end
        end
        if (q.cur_blk == q.end_blk) begin
          d.grant = !(q.denied || !blk_ok);
          d.fsm   = RAPU_REPLY;
        end
      end
      RAPU_REPLY: begin
        d.fsm = RAPU_IDLE;
      end
      default: begin
        d.fsm = RAPU_IDLE;
      end
    endcase

    // set wins over a same-cycle clear
    d.irq_stat = (q.irq_stat & ~clr) | ev;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !q.bus_ack;
  assign avs_readdata_o    = q.rdata;
  assign avs_response_o    = q.bresp;
  assign xfer_ready_o      = (q.fsm == RAPU_IDLE);
  assign resp_valid_o      = (q.fsm == RAPU_REPLY);
  assign resp_o.grant      = q.grant;
  assign resp_o.bus_error  = !q.grant;
  assign irq_o             = |(q.irq_stat & q.irq_mask);

endmodule : rapu_top

// ===== verification/rapu_sva.sv
`timescale 1ns/1ps
module rapu_sva
  import rapu_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  // register bus
  input wire logic [11:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [1:0]  avs_response_o,
  input wire logic        avs_waitrequest_o,
  // transfer check
  input wire logic        xfer_valid_i,
  input rapu_xfer_t       xfer_i,
  input wire logic        xfer_ready_o,
  input wire logic        resp_valid_o,
  input rapu_resp_t       resp_o
);
  // ------
  // properties
  // ------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic        acc;
  logic [12:0] span;
  assign acc  = xfer_valid_i && xfer_ready_o;
  assign span = {8'h00, xfer_i.addr[4:0]} + {1'b0, xfer_i.size_m1};
  chk_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("access not answered after one wait");
  chk_unmapped_err: assert property ((avs_read_i || avs_write_i) && !avs_waitrequest_o && !avs_address_i[11]
    && avs_address_i[4:3] != 2'h0 |-> avs_response_o == 2'h2) else $error("unmapped slot word not refused");
  chk_ready_drop: assert property (acc |=> !xfer_ready_o)
    else $error("ready stayed high after accept");
  chk_one_blk: assert property (acc && span < 13'h020 |=> !resp_valid_o ##1 resp_valid_o)
    else $error("single block verdict not after two edges");
  chk_two_blk: assert property (acc && span[12:5] == 8'h01 |=> !resp_valid_o [*2] ##1 resp_valid_o)
    else $error("two block verdict not after three edges");
  chk_err_inv: assert property (resp_valid_o |-> resp_o.bus_error != resp_o.grant)
    else $error("bus error not inverse of grant");
  chk_pulse_ready: assert property (resp_valid_o |=> !resp_valid_o && xfer_ready_o)
    else $error("verdict not a pulse followed by ready");
  chk_grant_hold: assert property (!resp_valid_o |-> $stable(resp_o.grant))
    else $error("grant moved between verdicts");
  chk_idle_ready: assert property (xfer_ready_o && !xfer_valid_i |=> xfer_ready_o)
    else $error("ready dropped while idle");
  cov_grant: cover property (resp_valid_o && resp_o.grant);
  cov_deny: cover property (resp_valid_o && resp_o.bus_error);
  cov_burst: cover property (acc && span[12:5] == 8'h01);
endmodule : rapu_sva

bind rapu_top rapu_sva u_sva (.ref_clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_response_o, .avs_waitrequest_o, .xfer_valid_i, .xfer_i, .xfer_ready_o, .resp_valid_o, .resp_o);

// ===== verification/rapu_master_bfm.sv
`timescale 1ns/1ps
module rapu_master_bfm
  import rapu_pkg::*;
(
  // clock
  input  wire logic ref_clk_i,
  // transfer request
  input  wire logic ready_i,
  output logic      valid_o = 1'b0,
  output rapu_xfer_t xfer_o = '0
);
  // ------
  // requester
  // ------
  // gap gives prompt and slow issue
  task send(input rapu_xfer_t t, input logic [1:0] gap, output logic ok);
    int n;
    repeat (gap) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    valid_o <= 1'b1;
    xfer_o  <= t;
    n = 0;
    @(negedge ref_clk_i);
    while (!ready_i && n < 99) begin
      n++;
      @(negedge ref_clk_i);
    end
    @(posedge ref_clk_i);
    valid_o <= 1'b0;
    // released fields show inverse, never stale data
    xfer_o  <= ~t;
    ok = n < 99;
  endtask : send
endmodule : rapu_master_bfm

// ===== verification/rapu_top_tb.sv
`timescale 1ns/1ps
module rapu_top_tb
  import rapu_pkg::*;
;
  logic        ref_clk_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        xfer_valid_i, xfer_ready_o, resp_valid_o, irq_o;
  logic [11:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [1:0]  avs_response_o;
  rapu_xfer_t  xfer_i;
  rapu_resp_t  resp_o;
  logic [31:0] rq[$];
  logic [1:0]  sq[$];
  logic        gq[$];
  logic [15:0] lf;
  int          fails, check_count;
  // addr, size-1, {write,exec,user,secure,context}, grant
  logic [55:0] tab [16] = '{
    56'h10005400_000_10_1,
    56'h10005400_000_11_0,
    56'h10005400_000_00_0,
    56'h10005400_000_30_0,
    56'h10005440_000_30_1,
    56'h100055c0_000_30_1,
    56'h10005580_000_30_0,
    56'h10005600_000_30_1,
    56'h10005400_000_50_0,
    56'h10005400_000_90_1,
    56'h10005400_000_23_1,
    56'h10005400_000_63_0,
    56'h10005400_000_12_1,
    56'h10005400_000_22_0,
    56'h10005400_000_12_0,
    56'h100053f0_01f_12_0
  };
  rapu_top DUT (.ref_clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i(4'hf),
    .avs_writedata_i, .avs_readdata_o, .avs_response_o, .avs_waitrequest_o, .xfer_valid_i, .xfer_i,
    .xfer_ready_o, .resp_valid_o, .resp_o, .irq_o);
  rapu_master_bfm u_bfm (.ref_clk_i, .ready_i(xfer_ready_o), .valid_o(xfer_valid_i), .xfer_o(xfer_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // ------
  // helpers
  // ------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task close_out;
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    if (!w) rq.push_back(d);
    // only base and rights words of a slot are mapped
    if (!w) sq.push_back((!a[11] && a[4:3] != 2'h0) ? 2'h2 : 2'h0);
    @(posedge ref_clk_i);
    avs_address_i   <= a;
    avs_read_i      <= !w;
    avs_write_i     <= w;
    avs_writedata_i <= d;
    n = 0;
    @(negedge ref_clk_i);
    while (avs_waitrequest_o && n < 99) begin
      n++;
      @(negedge ref_clk_i);
    end
    if (n == 99) begin
      fails++;
      close_out();
    end
    @(posedge ref_clk_i);
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task xf(input logic [31:0] a, input logic [11:0] sz, input logic [7:0] m, input logic g);
    logic ok;
    int   n;
    gq.push_back(g);
    u_bfm.send({a, sz, m}, lf[1:0], ok);
    lf = lfsr(lf);
    n = 0;
    while (gq.size() > 0 && n < 99) begin
      n++;
      @(posedge ref_clk_i);
    end
    if (!ok || n == 99) begin
      fails++;
      close_out();
    end
  endtask : xf
  task irq_is(input logic e);
    @(negedge ref_clk_i);
    chk("irq", {31'h0, e}, {31'h0, irq_o});
  endtask : irq_is
  // results are taken off the queues here
  always @(negedge ref_clk_i) begin
    if (resp_valid_o) chk("grant", {31'h0, gq.pop_front()}, {31'h0, resp_o.grant});
    if (avs_read_i && !avs_waitrequest_o) chk("rdata", rq.pop_front(), avs_readdata_o);
    if (avs_read_i && !avs_waitrequest_o) chk("resp", {30'h0, sq.pop_front()}, {30'h0, avs_response_o});
  end
  // ------
  // sequence
  // ------
  initial begin
    resetn_i        = 1'b0;
    avs_address_i   = 12'h000;
    avs_read_i      = 1'b0;
    avs_write_i     = 1'b0;
    avs_writedata_i = 32'h0;
    lf              = 16'hacd1;
    fails           = 0;
    check_count     = 0;
    repeat (3) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    xf(32'h1000_5400, 12'h000, 8'h11, 1'b1);
    bus(1'b1, 12'h020, 32'h1000_5482);
    bus(1'b1, 12'h024, 32'h0005_8818);
    bus(1'b0, 12'h024, 32'h0005_8818);
    for (int i = 0; i < 16; i++) begin
      if (i == 10) begin
        bus(1'b1, 12'h040, 32'h1000_5400);
        bus(1'b1, 12'h044, 32'h0008_88c1);
        bus(1'b0, 12'h044, 32'h0009_88c1);
      end
      if (i == 14) bus(1'b1, 12'h044, 32'h0008_8841);
      xf(tab[i][55:24], tab[i][23:12], tab[i][11:4], tab[i][0]);
    end
    repeat (8) xf({4'h2, lf, lf[11:0]}, {7'h00, lf[4:0]}, lf[7:0], 1'b1);
    bus(1'b0, 12'h800, 32'h0000_0003);
    irq_is(1'b0);
    bus(1'b1, 12'h804, 32'h0000_0001);
    bus(1'b0, 12'h804, 32'h0000_0001);
    irq_is(1'b1);
    bus(1'b1, 12'h800, 32'h0000_0001);
    bus(1'b0, 12'h800, 32'h0000_0002);
    irq_is(1'b0);
    bus(1'b0, 12'h008, 32'h0);
    resetn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    xf(32'h1000_5400, 12'h000, 8'h11, 1'b1);
    close_out();
  end
endmodule : rapu_top_tb
